// >>> hdl/tfrm_pkg.sv
package tfrm_pkg;

  // ==========================================================================
  // Register offsets (word index; byte address is four times the index)
  // ==========================================================================
  localparam logic [7:0] IDX_CONFIG_ONE = 8'h00;
  localparam logic [7:0] IDX_CONFIG_TWO = 8'h01;
  localparam logic [7:0] IDX_STATUS_ONE = 8'h02;
  localparam logic [7:0] IDX_STATUS_TWO = 8'h03;
  localparam logic [7:0] IDX_EXT_FRACTION = 8'h06;
  localparam logic [7:0] IDX_FACTORY_TEST = 8'h07;
  localparam logic [7:0] IDX_FAN_SPEED_COUNT = 8'h08;
  localparam logic [7:0] IDX_LOCAL_TEMP = 8'h0A;
  localparam logic [7:0] IDX_REMOTE_TEMP = 8'h0B;
  localparam logic [7:0] IDX_LOCAL_OFFSET = 8'h0D;
  localparam logic [7:0] IDX_REMOTE_OFFSET = 8'h0E;
  localparam logic [7:0] IDX_FAN_COUNT_LIMIT = 8'h10;
  localparam logic [7:0] IDX_LOCAL_HIGH = 8'h14;
  localparam logic [7:0] IDX_LOCAL_LOW = 8'h15;
  localparam logic [7:0] IDX_LOCAL_OVERTEMP = 8'h16;
  localparam logic [7:0] IDX_REMOTE_HIGH = 8'h18;
  localparam logic [7:0] IDX_REMOTE_LOW = 8'h19;
  localparam logic [7:0] IDX_REMOTE_OVERTEMP = 8'h1A;
  localparam logic [7:0] IDX_FAN_CHARACTERISTICS = 8'h20;
  localparam logic [7:0] IDX_FAN_SPEED_SETUP = 8'h22;
  localparam logic [7:0] IDX_FAN_FILTER = 8'h23;
  localparam logic [7:0] IDX_LOCAL_START_RANGE = 8'h24;
  localparam logic [7:0] IDX_REMOTE_START_RANGE = 8'h25;
  localparam logic [7:0] IDX_PART_ID = 8'h3D;
  localparam logic [7:0] IDX_MAKER_ID = 8'h3E;
  localparam logic [7:0] IDX_OT_REVISION = 8'h3F;

  // ==========================================================================
  // Reset values
  // ==========================================================================
  localparam logic [7:0] RST_CONFIG_ONE = 8'h90;
  localparam logic [7:0] RST_CONFIG_TWO = 8'h7F;
  localparam logic [7:0] RST_STATUS = 8'h00;
  localparam logic [7:0] RST_FAN_COUNT_LIMIT = 8'hFF;
  localparam logic [7:0] RST_LOCAL_HIGH = 8'h3C;
  localparam logic [7:0] RST_LOCAL_LOW = 8'h00;
  localparam logic [7:0] RST_LOCAL_OVERTEMP = 8'h46;
  localparam logic [7:0] RST_REMOTE_HIGH = 8'h50;
  localparam logic [7:0] RST_REMOTE_LOW = 8'h00;
  localparam logic [7:0] RST_REMOTE_OVERTEMP = 8'h64;
  localparam logic [7:0] RST_FAN_CHARACTERISTICS = 8'h5D;
  localparam logic [7:0] RST_FAN_SPEED_SETUP = 8'h55;
  localparam logic [7:0] RST_FAN_FILTER = 8'h55;
  localparam logic [7:0] RST_LOCAL_START_RANGE = 8'h41;
  localparam logic [7:0] RST_REMOTE_START_RANGE = 8'h61;
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [7:0] RST_OT_FORCE = 8'h00;

  // ==========================================================================
  // Field positions
  // ==========================================================================
  localparam int C1_MONITOR = 0;
  localparam int C1_INT_EN = 1;
  localparam int C1_SPEED_SENSE = 2;
  localparam int C1_DRIVE_INVERT = 3;
  localparam int C1_FAULT_EN = 4;
  localparam int C1_LOOP_LO = 5;
  localparam int C1_LOOP_HI = 6;
  localparam int C1_OWNER = 7;
  localparam int C2_DRIVE_EN = 0;
  localparam int C2_SENSE_EN = 2;
  localparam int C2_SOFT_RESET = 7;
  localparam int OTR_FORCE = 7;
  localparam logic [7:0] OTR_WRITE_MASK = 8'h80;

  // Automatic loop source encodings
  localparam logic [1:0] LOOP_REMOTE = 2'h0;
  localparam logic [1:0] LOOP_FASTEST = 2'h3;

  // ==========================================================================
  // Decoded control bundle
  // ==========================================================================
  typedef struct packed {
    logic monitor_enable;
    logic interrupt_enable;
    logic speed_sense_select;
    logic drive_invert;
    logic fault_output_enable;
    logic [1:0] loop_source;
    logic control_owner_select;
    logic drive_enable;
    logic sense_enable;
    logic overtemp_force_enable;
  } tfrm_ctrl_type;

  // Measurement inputs from the sensing engines
  typedef struct packed {
    logic [7:0] local_temp;
    logic [7:0] remote_temp;
    logic [7:0] fraction;
    logic [7:0] status_one;
    logic [7:0] status_two;
  } tfrm_meas_type;

endpackage

// >>> hdl/tfrm_regs.sv
`timescale 1ns/1ps
// ============================================================================
// What this block does
// - Config one bit 0 enables monitoring.
// - Config one bit 1 gates interrupt output.
// - Config one bit 2 selects analog speed sense.
// - Config one bit 3 inverts fan drive.
// - Config one bit 4 enables fan-failure output.
// - Config one bits 6-5 pick loop source.
// - Config one bit 7 selects automatic control.
// - Tach count above limit flags slow fan.
// - Part identifier at 0x3D, read only.
// - Maker identifier at 0x3E, read only.
// - 0x3F holds revision and overtemp force.
// - 0x0A/0x0B hold temperature value MSBs.
// - 0x08 holds tach count, read/write.
// - Limit registers load documented temperature defaults.
// - Config registers load defaults; status reads meas_i directly.
// - Fan setup registers load documented defaults.
// - 0x06 returns extended fraction bits.
// - Offsets at 0x0D/0x0E are read/write.
// - Config two enables drive and sense.
// - Config two bit 7 resets, self-clears.
// ============================================================================
module tfrm_regs #(
  parameter logic [7:0] PART_ID = 8'h5A,  // Arbitrary value
  parameter logic [7:0] MAKER_ID = 8'hA5, // Arbitrary value
  parameter logic [3:0] REVISION = 4'h1
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire tfrm_pkg::tfrm_meas_type meas_i,
  input wire logic tach_valid_i,
  input wire logic [7:0] tach_count_i,
  output tfrm_pkg::tfrm_ctrl_type ctrl_o,
  output logic fan_slow_o,
  output logic soft_reset_o
);

  // ==========================================================================
  // Bus decode
  // ==========================================================================
  logic ack_q;
  logic [31:0] dat_q;
  logic [5:0] word_idx;
  logic [7:0] idx;
  logic req;
  logic wr;
  logic [7:0] rd_byte;
  logic soft_rst;

  // Byte address is four times the index; data in the low lane
  assign word_idx = wb_adr_i[7:2];
  assign idx = {2'h0, word_idx};
  assign req = wb_cyc_i & wb_stb_i & ~ack_q;
  assign wr = req & wb_we_i & wb_sel_i[0];

  // ==========================================================================
  // Register storage
  // ==========================================================================
  logic [7:0] config_one_q;
  logic [7:0] config_two_q;
  logic [7:0] fan_speed_count_q;
  logic [7:0] local_offset_q;
  logic [7:0] remote_offset_q;
  logic [7:0] fan_count_limit_q;
  logic [7:0] local_high_q;
  logic [7:0] local_low_q;
  logic [7:0] local_overtemp_q;
  logic [7:0] remote_high_q;
  logic [7:0] remote_low_q;
  logic [7:0] remote_overtemp_q;
  logic [7:0] fan_char_q;
  logic [7:0] fan_setup_q;
  logic [7:0] fan_filter_q;
  logic [7:0] local_range_q;
  logic [7:0] remote_range_q;
  logic [7:0] ot_force_q;
  logic soft_reset_q;
  logic fan_slow_q;

  // Soft reset acts as a reset for one cycle after the write
  assign soft_rst = rst_i | soft_reset_q;

  // Config one: monitor and fan mode fields
  always_ff @(posedge clk_i) begin
    if (soft_rst) begin
      config_one_q <= tfrm_pkg::RST_CONFIG_ONE;
    end else if (wr && idx == tfrm_pkg::IDX_CONFIG_ONE) begin
      config_one_q <= wb_dat_i[7:0];
    end
  end

  // Config two: soft reset bit is never stored, so it reads zero
  always_ff @(posedge clk_i) begin
    if (soft_rst) begin
      config_two_q <= tfrm_pkg::RST_CONFIG_TWO;
    end else if (wr && idx == tfrm_pkg::IDX_CONFIG_TWO) begin
      config_two_q <= {1'b0, wb_dat_i[6:0]};
    end
  end

  // Fan characteristics
  always_ff @(posedge clk_i) begin
    if (soft_rst) begin
      fan_char_q <= tfrm_pkg::RST_FAN_CHARACTERISTICS;
    end else if (wr && idx == tfrm_pkg::IDX_FAN_CHARACTERISTICS) begin
      fan_char_q <= wb_dat_i[7:0];
    end
  end

  // Fan speed setup
  always_ff @(posedge clk_i) begin
    if (soft_rst) begin
      fan_setup_q <= tfrm_pkg::RST_FAN_SPEED_SETUP;
    end else if (wr && idx == tfrm_pkg::IDX_FAN_SPEED_SETUP) begin
      fan_setup_q <= wb_dat_i[7:0];
    end
  end

  // Fan filter
  always_ff @(posedge clk_i) begin
    if (soft_rst) begin
      fan_filter_q <= tfrm_pkg::RST_FAN_FILTER;
    end else if (wr && idx == tfrm_pkg::IDX_FAN_FILTER) begin
      fan_filter_q <= wb_dat_i[7:0];
    end
  end

  // Local start temperature and span
  always_ff @(posedge clk_i) begin
    if (soft_rst) begin
      local_range_q <= tfrm_pkg::RST_LOCAL_START_RANGE;
    end else if (wr && idx == tfrm_pkg::IDX_LOCAL_START_RANGE) begin
      local_range_q <= wb_dat_i[7:0];
    end
  end

  // Remote start temperature and span
  always_ff @(posedge clk_i) begin
    if (soft_rst) begin
      remote_range_q <= tfrm_pkg::RST_REMOTE_START_RANGE;
    end else if (wr && idx == tfrm_pkg::IDX_REMOTE_START_RANGE) begin
      remote_range_q <= wb_dat_i[7:0];
    end
  end

  // Overtemp force: only bit 7 is writable, revision is fixed
  always_ff @(posedge clk_i) begin
    if (soft_rst) begin
      ot_force_q <= tfrm_pkg::RST_OT_FORCE;
    end else if (wr && idx == tfrm_pkg::IDX_OT_REVISION) begin
      ot_force_q <= wb_dat_i[7:0] & tfrm_pkg::OTR_WRITE_MASK;
    end
  end

  // ==========================================================================
  // Limit and offset registers
  // ==========================================================================
  // Fan count limit
  always_ff @(posedge clk_i) begin
    if (soft_rst) begin
      fan_count_limit_q <= tfrm_pkg::RST_FAN_COUNT_LIMIT;
    end else if (wr && idx == tfrm_pkg::IDX_FAN_COUNT_LIMIT) begin
      fan_count_limit_q <= wb_dat_i[7:0];
    end
  end

  // Local high limit
  always_ff @(posedge clk_i) begin
    if (soft_rst) begin
      local_high_q <= tfrm_pkg::RST_LOCAL_HIGH;
    end else if (wr && idx == tfrm_pkg::IDX_LOCAL_HIGH) begin
      local_high_q <= wb_dat_i[7:0];
    end
  end

  // Local low limit
  always_ff @(posedge clk_i) begin
    if (soft_rst) begin
      local_low_q <= tfrm_pkg::RST_LOCAL_LOW;
    end else if (wr && idx == tfrm_pkg::IDX_LOCAL_LOW) begin
      local_low_q <= wb_dat_i[7:0];
    end
  end

  // Local overtemp limit
  always_ff @(posedge clk_i) begin
    if (soft_rst) begin
      local_overtemp_q <= tfrm_pkg::RST_LOCAL_OVERTEMP;
    end else if (wr && idx == tfrm_pkg::IDX_LOCAL_OVERTEMP) begin
      local_overtemp_q <= wb_dat_i[7:0];
    end
  end

  // Remote high limit
  always_ff @(posedge clk_i) begin
    if (soft_rst) begin
      remote_high_q <= tfrm_pkg::RST_REMOTE_HIGH;
    end else if (wr && idx == tfrm_pkg::IDX_REMOTE_HIGH) begin
      remote_high_q <= wb_dat_i[7:0];
    end
  end

  // Remote low limit
  always_ff @(posedge clk_i) begin
    if (soft_rst) begin
      remote_low_q <= tfrm_pkg::RST_REMOTE_LOW;
    end else if (wr && idx == tfrm_pkg::IDX_REMOTE_LOW) begin
      remote_low_q <= wb_dat_i[7:0];
    end
  end

  // Remote overtemp limit
  always_ff @(posedge clk_i) begin
    if (soft_rst) begin
      remote_overtemp_q <= tfrm_pkg::RST_REMOTE_OVERTEMP;
    end else if (wr && idx == tfrm_pkg::IDX_REMOTE_OVERTEMP) begin
      remote_overtemp_q <= wb_dat_i[7:0];
    end
  end

  // Local temperature offset
  always_ff @(posedge clk_i) begin
    if (soft_rst) begin
      local_offset_q <= tfrm_pkg::RST_ZERO;
    end else if (wr && idx == tfrm_pkg::IDX_LOCAL_OFFSET) begin
      local_offset_q <= wb_dat_i[7:0];
    end
  end

  // Remote temperature offset
  always_ff @(posedge clk_i) begin
    if (soft_rst) begin
      remote_offset_q <= tfrm_pkg::RST_ZERO;
    end else if (wr && idx == tfrm_pkg::IDX_REMOTE_OFFSET) begin
      remote_offset_q <= wb_dat_i[7:0];
    end
  end

  // Tach count: host write, or new measurement while monitoring with sense enabled; measurement wins
  always_ff @(posedge clk_i) begin
    if (soft_rst) begin
      fan_speed_count_q <= tfrm_pkg::RST_ZERO;
    end else if (tach_valid_i & ctrl_o.monitor_enable & ctrl_o.sense_enable) begin
      fan_speed_count_q <= tach_count_i;
    end else if (wr && idx == tfrm_pkg::IDX_FAN_SPEED_COUNT) begin
      fan_speed_count_q <= wb_dat_i[7:0];
    end
  end

  // Self-clearing soft reset request
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      soft_reset_q <= 1'b0;
    end else begin
      soft_reset_q <= wr & (idx == tfrm_pkg::IDX_CONFIG_TWO) & wb_dat_i[tfrm_pkg::C2_SOFT_RESET];
    end
  end

  // ==========================================================================
  // Control decode
  // ==========================================================================
  // Configuration fields fan out to the fan and monitor engines
  assign ctrl_o.monitor_enable = config_one_q[tfrm_pkg::C1_MONITOR];
  assign ctrl_o.interrupt_enable = config_one_q[tfrm_pkg::C1_INT_EN];
  assign ctrl_o.speed_sense_select = config_one_q[tfrm_pkg::C1_SPEED_SENSE];
  assign ctrl_o.drive_invert = config_one_q[tfrm_pkg::C1_DRIVE_INVERT];
  assign ctrl_o.fault_output_enable = config_one_q[tfrm_pkg::C1_FAULT_EN];
  assign ctrl_o.loop_source = config_one_q[tfrm_pkg::C1_LOOP_HI:tfrm_pkg::C1_LOOP_LO];
  assign ctrl_o.control_owner_select = config_one_q[tfrm_pkg::C1_OWNER];
  assign ctrl_o.drive_enable = config_two_q[tfrm_pkg::C2_DRIVE_EN];
  assign ctrl_o.sense_enable = config_two_q[tfrm_pkg::C2_SENSE_EN];
  assign ctrl_o.overtemp_force_enable = ot_force_q[tfrm_pkg::OTR_FORCE];
  assign soft_reset_o = soft_reset_q;

  // Slow or stalled fan: larger count means slower fan; flag is registered
  always_ff @(posedge clk_i) begin
    if (soft_rst) begin
      fan_slow_q <= 1'b0;
    end else begin
      fan_slow_q <= (fan_speed_count_q > fan_count_limit_q);
    end
  end
  assign fan_slow_o = fan_slow_q;

  // ==========================================================================
  // Read mux
  // ==========================================================================
  always_comb begin
    case (idx)
      tfrm_pkg::IDX_CONFIG_ONE: rd_byte = config_one_q;
      tfrm_pkg::IDX_CONFIG_TWO: rd_byte = config_two_q;
      tfrm_pkg::IDX_STATUS_ONE: rd_byte = meas_i.status_one;
      tfrm_pkg::IDX_STATUS_TWO: rd_byte = meas_i.status_two;
      tfrm_pkg::IDX_EXT_FRACTION: rd_byte = meas_i.fraction;
      tfrm_pkg::IDX_FAN_SPEED_COUNT: rd_byte = fan_speed_count_q;
      tfrm_pkg::IDX_LOCAL_TEMP: rd_byte = meas_i.local_temp;
      tfrm_pkg::IDX_REMOTE_TEMP: rd_byte = meas_i.remote_temp;
      tfrm_pkg::IDX_LOCAL_OFFSET: rd_byte = local_offset_q;
      tfrm_pkg::IDX_REMOTE_OFFSET: rd_byte = remote_offset_q;
      tfrm_pkg::IDX_FAN_COUNT_LIMIT: rd_byte = fan_count_limit_q;
      tfrm_pkg::IDX_LOCAL_HIGH: rd_byte = local_high_q;
      tfrm_pkg::IDX_LOCAL_LOW: rd_byte = local_low_q;
      tfrm_pkg::IDX_LOCAL_OVERTEMP: rd_byte = local_overtemp_q;
      tfrm_pkg::IDX_REMOTE_HIGH: rd_byte = remote_high_q;
      tfrm_pkg::IDX_REMOTE_LOW: rd_byte = remote_low_q;
      tfrm_pkg::IDX_REMOTE_OVERTEMP: rd_byte = remote_overtemp_q;
      tfrm_pkg::IDX_FAN_CHARACTERISTICS: rd_byte = fan_char_q;
      tfrm_pkg::IDX_FAN_SPEED_SETUP: rd_byte = fan_setup_q;
      tfrm_pkg::IDX_FAN_FILTER: rd_byte = fan_filter_q;
      tfrm_pkg::IDX_LOCAL_START_RANGE: rd_byte = local_range_q;
      tfrm_pkg::IDX_REMOTE_START_RANGE: rd_byte = remote_range_q;
      tfrm_pkg::IDX_PART_ID: rd_byte = PART_ID;
      tfrm_pkg::IDX_MAKER_ID: rd_byte = MAKER_ID;
      tfrm_pkg::IDX_OT_REVISION: rd_byte = ot_force_q | {4'h0, REVISION};
      default: rd_byte = 8'h00;
    endcase
  end

  // One-wait-state acknowledge with registered read data
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
      dat_q <= 32'h0000_0000;
    end else begin
      ack_q <= req;
      if (req & ~wb_we_i) dat_q <= {24'h00_0000, rd_byte};
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = dat_q;

endmodule // tfrm_regs

// >>> sim/tfrm_regs_chk.sv
`timescale 1ns/1ps
// ============================================================================
// Port checker for the register bank
// ============================================================================
module tfrm_regs_chk #(
  parameter logic [7:0] PART_ID = 8'h5A,
  parameter logic [7:0] MAKER_ID = 8'hA5,
  parameter logic [3:0] REVISION = 4'h1
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire tfrm_pkg::tfrm_meas_type meas_i,
  input wire logic tach_valid_i,
  input wire logic [7:0] tach_count_i,
  input wire tfrm_pkg::tfrm_ctrl_type ctrl_o,
  input wire logic fan_slow_o,
  input wire logic soft_reset_o
);
  localparam logic [10:0] CTRL_RST = 11'h04E;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // Taken requests and the written byte
  wire logic take_w = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire logic rd_w = take_w & ~wb_we_i;
  wire logic wr_w = take_w & wb_we_i & wb_sel_i[0];
  wire logic [5:0] idx_w = wb_adr_i[7:2];
  wire logic [7:0] wbyte_w = wb_dat_i[7:0];
  // ==========================================================================
  // Assertions
  // ==========================================================================
  a_ack_after_take: assert property (take_w |=> wb_ack_o)
    else $error("no ack after a taken request");
  a_upper_zero: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h00_0000)
    else $error("read data upper bits not zero");
  a_unmapped_zero: assert property ((rd_w && idx_w inside {6'h04, [6'h26:6'h3C]}) |=> wb_dat_o == 32'h0000_0000)
    else $error("unmapped read not zero");
  a_part_id: assert property ((rd_w && idx_w == 6'h3D) |=> wb_dat_o[7:0] == PART_ID)
    else $error("part identifier wrong");
  a_maker_id: assert property ((rd_w && idx_w == 6'h3E) |=> wb_dat_o[7:0] == MAKER_ID)
    else $error("maker identifier wrong");
  a_rev_bits: assert property ((rd_w && idx_w == 6'h3F) |=> wb_dat_o[3:0] == REVISION)
    else $error("revision bits wrong");
  a_cfg1_write: assert property ((wr_w && idx_w == 6'h00) |=> {ctrl_o.control_owner_select, ctrl_o.loop_source, ctrl_o.fault_output_enable, ctrl_o.drive_invert, ctrl_o.speed_sense_select, ctrl_o.interrupt_enable, ctrl_o.monitor_enable} == $past(wbyte_w))
    else $error("config one fields do not follow write");
  a_cfg2_enables: assert property ((wr_w && idx_w == 6'h01 && !wbyte_w[7]) |=> {ctrl_o.sense_enable, ctrl_o.drive_enable} == {$past(wbyte_w[2]), $past(wbyte_w[0])})
    else $error("config two enables do not follow write");
  a_reset_ctrl: assert property ($past(rst_i) |-> (ctrl_o == CTRL_RST && !fan_slow_o && !wb_ack_o))
    else $error("outputs wrong after reset");
  a_ctrl_hold: assert property ((!$past(wr_w) && !$past(soft_reset_o) && !$past(rst_i)) |-> $stable(ctrl_o))
    else $error("controls changed without a write");
  a_soft_pulse: assert property ((wr_w && idx_w == 6'h01 && wbyte_w[7]) |-> ##[1:2] soft_reset_o)
    else $error("soft reset not raised");
  a_soft_defaults: assert property (soft_reset_o |=> (!soft_reset_o && ctrl_o == CTRL_RST))
    else $error("soft reset did not restore defaults");
endmodule // tfrm_regs_chk

bind tfrm_regs tfrm_regs_chk #(.PART_ID(PART_ID), .MAKER_ID(MAKER_ID), .REVISION(REVISION)) u_chk (
  .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
  .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .meas_i(meas_i), .tach_valid_i(tach_valid_i), .tach_count_i(tach_count_i), .ctrl_o(ctrl_o),
  .fan_slow_o(fan_slow_o), .soft_reset_o(soft_reset_o));

// >>> sim/tfrm_host.sv
`timescale 1ns/1ps
// ============================================================================
// Host controller model: classic single Wishbone cycles
// ============================================================================
module tfrm_host (
  input wire logic clk_i,
  input wire logic ack_i,
  input wire logic [31:0] dat_i,
  output logic cyc_o,
  output logic stb_o,
  output logic we_o,
  output logic [7:0] adr_o,
  output logic [3:0] sel_o,
  output logic [31:0] dat_o
);
  // Idle bus from time zero
  initial begin
    {cyc_o, stb_o, we_o, adr_o, sel_o, dat_o} = '0;
  end
  // One cycle held until ack; callers never touch the factory test slot
  task automatic xfer(input logic w, input logic [5:0] idx, input logic [7:0] v, output logic [7:0] r);
    @(posedge clk_i);
    {cyc_o, stb_o, we_o, sel_o} <= {2'h3, w, 4'h1};
    adr_o <= {idx, 2'h0};
    dat_o <= {24'h00_0000, v};
    do @(posedge clk_i); while (ack_i !== 1'h1);
    r = dat_i[7:0];
    {cyc_o, stb_o, we_o} <= 3'h0;
    adr_o <= ~{idx, 2'h0}; // Released lines show garbage
    dat_o <= ~{24'h00_0000, v};
  endtask
  task automatic wr(input logic [5:0] idx, input logic [7:0] v);
    logic [7:0] r;
    xfer(1'h1, idx, v, r);
  endtask
  task automatic rd(input logic [5:0] idx, output logic [7:0] r);
    xfer(1'h0, idx, 8'h00, r);
  endtask
endmodule // tfrm_host

// >>> sim/tb_top.sv
`timescale 1ns/1ps
// ============================================================================
// Testbench for the register bank
// ============================================================================
module tb_top;
  logic clk_i, rst_i, tach_valid_i, cyc, stb, we, ack, slow, sreset;
  logic [7:0] adr, tcnt, rdat;
  logic [3:0] sel;
  logic [31:0] wdat, bdat;
  tfrm_pkg::tfrm_meas_type meas;
  tfrm_pkg::tfrm_ctrl_type ctrl;
  int err_total, checks, sr_cnt;
  // Rows: index, write flag, write byte, expected read byte
  logic [31:0] rows [0:32] = '{32'h0000_0090, 32'h0100_007F, 32'h1000_00FF, 32'h1400_003C, 32'h1500_0000,
    32'h1600_0046, 32'h1800_0050, 32'h1900_0000, 32'h1A00_0064, 32'h2000_005D, 32'h2200_0055, 32'h2300_0055,
    32'h2400_0041, 32'h2500_0061, 32'h3D00_005A, 32'h3E00_00A5, 32'h3F00_0001, 32'h0200_0011, 32'h0300_0080,
    32'h0600_00C4, 32'h0A00_002A, 32'h0B00_003B, 32'h0D01_A5A5, 32'h0E01_5A5A, 32'h0801_C3C3, 32'h3D01_005A,
    32'h0B01_FF3B, 32'h0201_FF11, 32'h3F01_FF81, 32'h0401_FF00, 32'h0101_0505, 32'h2501_3C3C, 32'h1401_C8C8};
  logic [7:0] modes [0:7] = '{8'h01, 8'h02, 8'h04, 8'h08, 8'h10, 8'h60, 8'h80, 8'h00};

  tfrm_regs DUT (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(bdat), .wb_ack_o(ack), .meas_i(meas), .tach_valid_i(tach_valid_i),
    .tach_count_i(tcnt), .ctrl_o(ctrl), .fan_slow_o(slow), .soft_reset_o(sreset));
  tfrm_host u_host (.clk_i(clk_i), .ack_i(ack), .dat_i(bdat), .cyc_o(cyc), .stb_o(stb), .we_o(we), .adr_o(adr),
    .sel_o(sel), .dat_o(wdat));

  // ==========================================================================
  // Clock, pulse counter, watchdog
  // ==========================================================================
  initial begin
    clk_i = 1'h0;
    forever #4 clk_i = ~clk_i;
  end
  always @(posedge clk_i) if (sreset === 1'h1) sr_cnt++;
  initial begin
    #200000;
    err_total++;
    finish_test();
  end

  // ==========================================================================
  // Helpers
  // ==========================================================================
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // One tach result pulse, then let the count and the registered flag settle
  task automatic tach(input logic [7:0] c);
    @(posedge clk_i);
    tach_valid_i <= 1'h1;
    tcnt <= c;
    @(posedge clk_i);
    tach_valid_i <= 1'h0;
    tcnt <= ~c;
    @(posedge clk_i);
    @(posedge clk_i);
  endtask
  // Controls expected from a config one byte, with drive, sense and force on
  function automatic logic [10:0] exp_ctrl(input logic [7:0] m);
    return {m[0], m[1], m[2], m[3], m[4], m[6:5], m[7], 3'h7};
  endfunction

  // ==========================================================================
  // Main sequence
  // ==========================================================================
  initial begin
    {rst_i, tach_valid_i, tcnt, err_total, checks, sr_cnt} = {1'h1, 1'h0, 8'h00, 96'h0};
    meas = 40'h2A_3BC4_1180;
    repeat (16) @(posedge clk_i);
    rst_i <= 1'h0;
    foreach (rows[i]) begin
      if (rows[i][16]) u_host.wr(rows[i][29:24], rows[i][15:8]);
      u_host.rd(rows[i][29:24], rdat);
      check($sformatf("reg %h", rows[i][31:24]), rdat, rows[i][7:0]);
    end
    $display("test register table done");
    foreach (modes[k]) begin
      u_host.wr(6'h00, modes[k]);
      check($sformatf("ctrl %h", modes[k]), ctrl, exp_ctrl(modes[k]));
    end
    $display("test config one fields done");
    u_host.wr(6'h00, 8'h01);
    u_host.wr(6'h10, 8'h80);
    tach(8'h81);
    check("slow above limit", slow, 1'h1);
    u_host.rd(6'h08, rdat);
    check("tach count", rdat, 8'h81);
    tach(8'h80);
    check("slow at limit", slow, 1'h0);
    u_host.wr(6'h00, 8'h00);
    tach(8'hFF);
    check("slow while idle", slow, 1'h0);
    $display("test tach limit done");
    u_host.wr(6'h01, 8'h80);
    repeat (3) @(posedge clk_i);
    check("soft pulses", sr_cnt, 1);
    check("ctrl after soft", ctrl, 11'h04E);
    u_host.rd(6'h01, rdat);
    check("config two", rdat, 8'h7F);
    u_host.rd(6'h10, rdat);
    check("limit after soft", rdat, 8'hFF);
    $display("test soft reset done");
    u_host.wr(6'h00, 8'hFF);
    rst_i <= 1'h1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'h0;
    @(posedge clk_i);
    check("ctrl after reset", ctrl, 11'h04E);
    u_host.rd(6'h00, rdat);
    check("config one", rdat, 8'h90);
    $display("test mid-run reset done");
    finish_test();
  end
endmodule // tb_top
